// >>> logic/csi_dphy_timing_override_regs.sv
// Timing override register bank for the first D-PHY transmit port
// What this block does
// - Clock post-time uses the automatic value unless its override bit is set.
// - Data prepare-time uses the programmed value only when its override bit is set.
// - Data zero-time uses the automatic value while its override bit is clear.
// - Data trail-time uses the programmed value only with its override bit set.
// - Data exit-time is automatic unless its override bit is set.
// - LP transition time is automatic unless its override bit is set.
// - With override clear the value field reads the automatic value and is not writable.
// - With override set the value field is writable and reads back the stored value.
// - The clock post-time value sits in bits 6:0 and is used when override is set.
//
// Design decision made here: the APB interface to the registers.
`include "dphy_timing_cfg.svh"
`timescale 1ns/1ps

module csi_dphy_timing_override_regs
    import dphy_timing_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Automatic values from the timing calculator
    input wire logic [6:0] auto_clock_post,
    input wire logic [6:0] auto_data_prepare,
    input wire logic [6:0] auto_data_zero,
    input wire logic [6:0] auto_data_trail,
    input wire logic [6:0] auto_data_exit,
    input wire logic [6:0] auto_lp_transition,
    // Values in force toward the timing generator
    output logic [6:0] clock_post_time,
    output logic [6:0] data_prepare_time,
    output logic [6:0] data_zero_time,
    output logic [6:0] data_trail_time,
    output logic [6:0] data_exit_time,
    output logic [6:0] lp_transition_time
);

    // ****************************************
    // Decode
    // ****************************************
    logic hit;
    timing_sel_t sel;
    logic wr_stb;
    logic rd_stb;
    logic [`NUM_TIMING_REGS-1:0] slot_wr;
    logic [`NUM_TIMING_REGS-1:0] ov_en;
    timing_value_t auto_vec [`NUM_TIMING_REGS];
    timing_value_t force_vec [`NUM_TIMING_REGS];
    logic [7:0] read_vec [`NUM_TIMING_REGS];
    timing_value_t stored_vec [`NUM_TIMING_REGS];

    apb_byte_slave apb_byte_slave_i
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .hit(hit),
        .sel(sel),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb)
    );

    assign auto_vec[0] = auto_clock_post;
    assign auto_vec[1] = auto_data_prepare;
    assign auto_vec[2] = auto_data_zero;
    assign auto_vec[3] = auto_data_trail;
    assign auto_vec[4] = auto_data_exit;
    assign auto_vec[5] = auto_lp_transition;

    // ****************************************
    // Register slots
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `NUM_TIMING_REGS; g++)
        begin : g_slot
            // Byte lane 0 only carries the register
            assign slot_wr[g] = wr_stb && pstrb[0] && (sel == timing_sel_t'(3'(g)));
            timing_override_slot timing_override_slot_i
            (
                .mclk(mclk),
                .rst_n(rst_n),
                .wr_en(slot_wr[g]),
                .wr_data(pwdata[7:0]),
                .auto_value(auto_vec[g]),
                .override_en(ov_en[g]),
                .in_force(force_vec[g]),
                .read_value(read_vec[g])
            );
            // Stored value, watched by the assertions only
            assign stored_vec[g] = timing_override_slot_i.value_reg;
        end
    endgenerate

    // ****************************************
    // Registered outputs
    // ****************************************
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;
    timing_value_t out_next [`NUM_TIMING_REGS];
    timing_value_t out_reg [`NUM_TIMING_REGS];
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    always_comb
    begin
        // Answer lands in the cycle after setup, so access phase is one cycle
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !hit;
        prdata_next = 32'h0000_0000;
        if (psel && !penable && !pwrite && hit)
        begin
            prdata_next = {24'h00_0000, read_vec[sel]};
        end
        for (int i = 0; i < `NUM_TIMING_REGS; i++)
        begin
            out_next[i] = force_vec[i];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            for (int i = 0; i < `NUM_TIMING_REGS; i++)
                out_reg[i] <= `VALUE_RESET;
        end
        else
        begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            for (int i = 0; i < `NUM_TIMING_REGS; i++)
                out_reg[i] <= out_next[i];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign clock_post_time = out_reg[0];
    assign data_prepare_time = out_reg[1];
    assign data_zero_time = out_reg[2];
    assign data_trail_time = out_reg[3];
    assign data_exit_time = out_reg[4];
    assign lp_transition_time = out_reg[5];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Antecedents want rst_n too: the release edge still shows reset values
    logic setup_cycle;
    logic read_setup;

    assign setup_cycle = psel && !penable;
    assign read_setup = setup_cycle && !pwrite && hit;

    // ****************************************
    // Automatic values in force
    // ****************************************
    a_clock_post_auto: assert property (
        rst_n && !ov_en[0]
        |=> clock_post_time == $past(auto_clock_post))
        else $error("clock post not automatic");

    a_prepare_auto: assert property (
        rst_n && !ov_en[1]
        |=> data_prepare_time == $past(auto_data_prepare))
        else $error("prepare time not automatic");

    a_zero_auto: assert property (
        rst_n && !ov_en[2]
        |=> data_zero_time == $past(auto_data_zero))
        else $error("zero time not automatic");

    a_trail_auto: assert property (
        rst_n && !ov_en[3]
        |=> data_trail_time == $past(auto_data_trail))
        else $error("trail time not automatic");

    a_exit_auto: assert property (
        rst_n && !ov_en[4]
        |=> data_exit_time == $past(auto_data_exit))
        else $error("exit time not automatic");

    a_plx_auto: assert property (
        rst_n && !ov_en[5]
        |=> lp_transition_time == $past(auto_lp_transition))
        else $error("lp transition not automatic");

    // ****************************************
    // Programmed values in force
    // ****************************************
    a_clock_post_held: assert property (
        rst_n && ov_en[0]
        |=> clock_post_time == $past(stored_vec[0]))
        else $error("clock post override not in force");

    a_prepare_held: assert property (
        rst_n && ov_en[1]
        |=> data_prepare_time == $past(stored_vec[1]))
        else $error("prepare override not in force");

    a_prepare_pick: assert property (
        rst_n && ov_en[1] && $stable(ov_en[1]) && !slot_wr[1]
        |=> data_prepare_time == $past(data_prepare_time, 1) || $past(slot_wr[1], 2))
        else $error("prepare override value drifted");

    a_zero_held: assert property (
        rst_n && ov_en[2]
        |=> data_zero_time == $past(stored_vec[2]))
        else $error("zero override not in force");

    a_trail_held: assert property (
        rst_n && ov_en[3]
        |=> data_trail_time == $past(stored_vec[3]))
        else $error("trail override not in force");

    a_exit_held: assert property (
        rst_n && ov_en[4]
        |=> data_exit_time == $past(stored_vec[4]))
        else $error("exit override not in force");

    a_plx_held: assert property (
        rst_n && ov_en[5]
        |=> lp_transition_time == $past(stored_vec[5]))
        else $error("lp transition override not in force");

    // ****************************************
    // Register access
    // ****************************************
    a_read_auto: assert property (
        rst_n && read_setup && !ov_en[sel]
        |=> pready && !prdata[7] && prdata[6:0] == $past(auto_vec[sel]))
        else $error("read did not show automatic value");

    a_read_stored: assert property (
        rst_n && read_setup && ov_en[sel]
        |=> pready && prdata[7] && prdata[6:0] == $past(stored_vec[sel]))
        else $error("read did not show stored value");

    a_write_stored: assert property (
        rst_n && slot_wr[0] && ov_en[0] && pwdata[7]
        |=> ##1 clock_post_time == $past(pwdata[6:0], 2))
        else $error("override write not in force");

    a_write_ignored: assert property (
        rst_n && slot_wr[0] && !ov_en[0] && pwdata[7]
        |=> ov_en[0] && force_vec[0] == $past(stored_vec[0]))
        else $error("value write with override clear took effect");

    a_value_locked: assert property (
        rst_n && wr_stb && pstrb[0] && !ov_en[sel]
        |=> stored_vec[$past(sel)] == $past(stored_vec[sel]))
        else $error("value field written with override clear");

    // ****************************************
    // Bus answer
    // ****************************************
    a_ready_one: assert property ( // bus
        rst_n && setup_cycle
        |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    a_ready_idle: assert property ( // bus
        rst_n && !setup_cycle
        |=> !pready && !pslverr)
        else $error("apb answer without setup");

    a_err_unmapped: assert property ( // bus
        rst_n && setup_cycle
        |=> pready && pslverr == !$past(hit))
        else $error("slave error does not match decode");

    a_rdata_idle: assert property ( // bus
        rst_n && !read_setup
        |=> prdata == 32'h0000_0000)
        else $error("read data outside a read answer");

    a_rdata_upper: assert property ( // bus
        rst_n
        |=> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    a_refused_write: assert property ( // bus
        rst_n && psel && penable && pwrite && (!hit || !pstrb[0])
        |=> $stable(ov_en))
        else $error("refused write changed an override");

    c_override_write: cover property (slot_wr[0] && ov_en[0]);
    c_read_auto: cover property (rd_stb && hit && !ov_en[sel]);
    c_read_stored: cover property (read_setup && ov_en[sel]);
    c_unmapped: cover property (pslverr);
    c_all_override: cover property (&ov_en);

endmodule : csi_dphy_timing_override_regs

// >>> logic/dphy_timing_cfg.svh
// Offsets, field positions and reset values of the timing override registers
`ifndef DPHY_TIMING_CFG_SVH
`define DPHY_TIMING_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_CLOCK_POST 8'h43
`define IDX_DATA_PREPARE 8'h44
`define IDX_DATA_ZERO 8'h45
`define IDX_DATA_TRAIL 8'h46
`define IDX_DATA_EXIT 8'h47
`define IDX_LP_TRANSITION 8'h48
`define IDX_FIRST 8'h43
`define NUM_TIMING_REGS 6

// Field layout
`define OVERRIDE_BIT 7
`define VALUE_MSB 6
`define VALUE_LSB 0

// Reset values
`define OVERRIDE_RESET 1'h0
`define VALUE_RESET 7'h00

`endif

// >>> logic/dphy_timing_pkg.sv
// Types shared by the timing override register bank
package dphy_timing_pkg;

    typedef logic [6:0] timing_value_t;

    typedef enum logic [2:0]
    {
        SEL_CLOCK_POST,
        SEL_DATA_PREPARE,
        SEL_DATA_ZERO,
        SEL_DATA_TRAIL,
        SEL_DATA_EXIT,
        SEL_LP_TRANSITION
    } timing_sel_t;

    typedef enum logic [1:0]
    {
        APB_IDLE,
        APB_ACCESS
    } apb_state_t;

endpackage : dphy_timing_pkg

// >>> logic/timing_override_slot.sv
// One override register: enable bit, stored value and selected output
`include "dphy_timing_cfg.svh"
`timescale 1ns/1ps

module timing_override_slot
    import dphy_timing_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register write
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Timing generator side
    input wire timing_value_t auto_value,
    output logic override_en,
    output timing_value_t in_force,
    output logic [7:0] read_value
);

    logic override_reg;
    logic override_next;
    timing_value_t value_reg;
    timing_value_t value_next;

    always_comb
    begin
        override_next = override_reg;
        value_next = value_reg;
        if (wr_en)
        begin
            override_next = wr_data[`OVERRIDE_BIT];
            if (override_reg)
            begin
                value_next = wr_data[`VALUE_MSB:`VALUE_LSB];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            override_reg <= `OVERRIDE_RESET;
            value_reg <= `VALUE_RESET;
        end
        else
        begin
            override_reg <= override_next;
            value_reg <= value_next;
        end
    end

    assign override_en = override_reg;
    assign in_force = override_reg ? value_reg : auto_value;
    assign read_value = {override_reg, in_force};

endmodule : timing_override_slot

// >>> logic/apb_byte_slave.sv
// APB slave front end: decodes word index, one-wait-free access
`include "dphy_timing_cfg.svh"
`timescale 1ns/1ps

module apb_byte_slave
    import dphy_timing_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB address and strobes
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    // Decode results
    output logic hit,
    output timing_sel_t sel,
    output logic wr_stb,
    output logic rd_stb
);

    apb_state_t state_reg;
    apb_state_t state_next;
    logic [9:0] index;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            APB_IDLE: if (psel && !penable) state_next = APB_ACCESS;
            APB_ACCESS: state_next = (psel && !penable) ? APB_ACCESS : APB_IDLE;
            default: state_next = APB_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_reg <= APB_IDLE;
        else
            state_reg <= state_next;
    end

    assign index = paddr[11:2];
    assign hit = (paddr[1:0] == 2'h0) && (index >= 10'(`IDX_FIRST))
        && (index < 10'(`IDX_FIRST) + 10'(`NUM_TIMING_REGS));
    assign sel = timing_sel_t'(3'(index - 10'(`IDX_FIRST)));
    // Access phase always completes in one cycle
    // Strobes only inside a real access phase, never on a stray penable
    assign wr_stb = psel && penable && pwrite && hit && (state_reg == APB_ACCESS);
    assign rd_stb = psel && penable && !pwrite && (state_reg == APB_ACCESS);

endmodule : apb_byte_slave

// >>> tb/csi_dphy_timing_override_regs_test.sv
// Self-checking bench for the timing override register bank
`timescale 1ns/1ps

module csi_dphy_timing_override_regs_test
    import dphy_timing_pkg::*;
;
    typedef struct
    {
        logic [11:0] addr;
        logic [7:0] wd;
        logic strb;
        logic [7:0] rd;
        logic [6:0] out;
        int idx;
    } row_t;

    logic mclk;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] auto_v [6] = '{7'h11, 7'h22, 7'h33, 7'h44, 7'h55, 7'h66};
    wire [6:0] outs [6];
    row_t rows [30];
    int n_errors = 0;
    int checked = 0;

    csi_dphy_timing_override_regs csi_dphy_timing_override_regs_i (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .auto_clock_post(auto_v[0]), .auto_data_prepare(auto_v[1]),
        .auto_data_zero(auto_v[2]), .auto_data_trail(auto_v[3]),
        .auto_data_exit(auto_v[4]), .auto_lp_transition(auto_v[5]),
        .clock_post_time(outs[0]), .data_prepare_time(outs[1]),
        .data_zero_time(outs[2]), .data_trail_time(outs[3]),
        .data_exit_time(outs[4]), .lp_transition_time(outs[5])
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ****************************************
    // Bus cycle and compare tasks
    // ****************************************
    // Upper write bits carry junk on purpose; they must never read back
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic s, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'hA5A5A5, d};
        pstrb <= {3'h0, s};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20)
            n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_err(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t slverr got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_err

    task automatic chk_out(input logic [6:0] got, input logic [6:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t timing got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out

    task automatic print_verdict();
        $display("Checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [31:0] rd;
        logic er;
        logic [11:0] a;
        logic [6:0] v;
        for (int i = 0; i < 6; i++)
        begin
            a = 12'h10C + 12'(4 * i);
            v = 7'h40 | 7'(i);
            rows[5 * i] = '{a, 8'h05, 1'b1, {1'b0, auto_v[i]}, auto_v[i], i};
            rows[5 * i + 1] = '{a, 8'h80, 1'b1, 8'h80, 7'h00, i};
            rows[5 * i + 2] = '{a, {1'b1, v}, 1'b1, {1'b1, v}, v, i};
            rows[5 * i + 3] = '{a, 8'h2A, 1'b0, {1'b1, v}, v, i};
            rows[5 * i + 4] = '{a, 8'h00, 1'b1, {1'b0, auto_v[i]}, auto_v[i], i};
        end
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 12'h10C + 12'(4 * i), 8'h00, 1'b0, rd, er);
            chk_rd(rd, {25'h0, auto_v[i]});
            chk_out(outs[i], auto_v[i]);
        end
        foreach (rows[k])
        begin
            apb(1'b1, rows[k].addr, rows[k].wd, rows[k].strb, rd, er);
            chk_err(er, 1'b0);
            apb(1'b0, rows[k].addr, 8'h00, 1'b0, rd, er);
            chk_rd(rd, {24'h0, rows[k].rd});
            chk_out(outs[rows[k].idx], rows[k].out);
        end
        // Automatic value moves while override is clear
        auto_v[2] <= 7'h7F;
        repeat (3) @(posedge mclk);
        chk_out(outs[2], 7'h7F);
        apb(1'b0, 12'h114, 8'h00, 1'b0, rd, er);
        chk_rd(rd, 32'h0000007F);
        // Unmapped and misaligned places refuse
        apb(1'b0, 12'h124, 8'h00, 1'b0, rd, er);
        chk_err(er, 1'b1);
        chk_rd(rd, 32'h0);
        apb(1'b0, 12'h108, 8'h00, 1'b0, rd, er);
        chk_err(er, 1'b1);
        apb(1'b1, 12'h10D, 8'h80, 1'b1, rd, er);
        chk_err(er, 1'b1);
        apb(1'b0, 12'h10C, 8'h00, 1'b0, rd, er);
        chk_rd(rd, {25'h0, auto_v[0]});
        // Programmed value holds against a moving automatic value
        apb(1'b1, 12'h120, 8'h80, 1'b1, rd, er);
        apb(1'b1, 12'h120, 8'h93, 1'b1, rd, er);
        auto_v[5] <= 7'h01;
        repeat (3) @(posedge mclk);
        chk_out(outs[5], 7'h13);
        // Reset in mid-run drops the override
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_out(outs[5], 7'h00);
        rst_n <= 1'b1;
        apb(1'b0, 12'h120, 8'h00, 1'b0, rd, er);
        chk_rd(rd, 32'h00000001);
        chk_out(outs[5], 7'h01);
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
endmodule : csi_dphy_timing_override_regs_test
